// file: logic/rxdd_top.sv
// Operation
// - dpll oversamples at 32x data rate
// - loop tracks rate error of two percent
// - select 01 correlator, 00 linear fsk
// - select 10 ask envelope detection
// - postfilter cutoff from 10-bit value
// - linear discriminator filtered, averaged, sliced
// - linear slicer feeds the dpll
// - frequency correction only in fsk modes
// - signed 16-bit frequency readback
// - enable bit starts pi correction loop
// - correction clamped by if bandwidth
// - sync match asserts interrupt pin
// - pin drops after nine recovered bits
// - sync detection only modes 010, 011
// - sync length 12, 16, 20, 24
// - accept up to tolerance mismatched bits
// - correlator compares upper and lower levels
// - correlator slicer threshold fixed zero
`include "rxdd_cfg.svh"
module rxdd_top
  import rxdd_pkg::*;
#(
  parameter int DW = 16
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire logic signed [DW-1:0] corr_upper,
  input  wire logic signed [DW-1:0] corr_lower,
  input  wire logic signed [DW-1:0] discrim_freq,
  input  wire logic [6:0]           signal_strength,
  output logic                      rx_data,
  output logic                      rx_clk,
  output logic                      sync_match_int,
  output logic signed [15:0]        freq_adjust
);
  initial begin
    if (DW < 8 || DW > 16) $error("rxdd_top: DW must be 8..16");
  end

  typedef struct packed {
    rxdd_cfg_type       cfg;
    rxdd_ahb_state_type ahb_st;
    rxdd_ahb_req_type   req;
    logic [31:0]        rdata;
    logic signed [DW+3:0] filt;
    logic signed [DW+3:0] avg;
    logic signed [DW+3:0] favg;
    logic [4:0]         phase;
    logic               slice_d;
    logic               bit_out;
    logic               clk_out;
    logic [23:0]        shreg;
    logic [3:0]         hold;
    logic               int_out;
    logic signed [15:0] measured_if_frequency;
    logic signed [23:0] integ;
    logic signed [15:0] adj;
  } rxdd_state_type;

  rxdd_state_type r;
  rxdd_state_type next_r;

  ////////////////////////////////////////////////////////////////////////////
  // mismatch count over the selected window
  logic [23:0] len_mask;
  logic [23:0] diff;
  logic [4:0]  errs;
  always_comb begin
    unique case (r.cfg.sync_len)
      2'h0:    len_mask = 24'h000fff;
      2'h1:    len_mask = 24'h00ffff;
      2'h2:    len_mask = 24'h0fffff;
      default: len_mask = 24'hffffff;
    endcase
    diff = (r.shreg ^ r.cfg.sync_word) & len_mask;
    errs = 5'h00;
    for (int i = 0; i < 24; i++) begin
      errs = errs + {4'h0, diff[i]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic signed [DW+3:0] demod_in;
  logic signed [DW+15:0] fstep;
  logic                 slice;
  logic                 is_fsk;
  logic                 sync_on;
  logic                 bit_tick;
  logic                 sample_pt;
  logic signed [15:0]   ferr;
  logic signed [15:0]   lim;
  logic signed [39:0]   prod;
  logic signed [23:0]   sum_adj;
  logic [11:0]          a_off;

  always_comb begin
    next_r = r;
    // demodulator source select
    unique case (r.cfg.demod_sel)
      `RXDD_DSEL_CORR: demod_in = (DW+4)'(corr_upper) - (DW+4)'(corr_lower);
      `RXDD_DSEL_LIN:  demod_in = (DW+4)'(discrim_freq);
      `RXDD_DSEL_ASK:  demod_in = (DW+4)'($signed({1'b0, signal_strength}));
      default:         demod_in = '0;
    endcase
    // first-order iir, gain is value / 2^10, i.e. 2*pi*fc/clk
    // a multiply, not a shift: shifts only give octave steps of cutoff
    fstep = (DW+16)'(demod_in - r.filt) *
            (DW+16)'($signed({1'b0, r.cfg.postfilter_bandwidth_value}));
    next_r.filt = r.filt + (DW+4)'(fstep >>> 10);
    // averaging envelope for the slicer threshold only
    next_r.avg = r.avg + ((r.filt - r.avg) >>> 6);
    // if estimate always from the discriminator, whatever path is sliced
    next_r.favg = r.favg + (((DW+4)'(discrim_freq) - r.favg) >>> 6);
    if (r.cfg.demod_sel == `RXDD_DSEL_CORR) begin
      slice = r.filt > 0;
    end else begin
      slice = r.filt > r.avg;
    end
    slice = slice ^ r.cfg.rx_polarity_bit;
    // dpll: 32 phases per bit, nudged at each transition
    bit_tick = 1'b0;
    next_r.slice_d = slice;
    if (slice != r.slice_d) begin
      // correction of one step per edge covers +-2% rate error
      if (r.phase < 5'd16) next_r.phase = r.phase + 5'd2;
      else next_r.phase = r.phase;
    end else begin
      next_r.phase = r.phase + 5'd1;
    end
    // edges settle at phase 16, so phase 0 is mid-bit; 0 is never jumped over
    sample_pt = (r.phase == 5'd0);
    if (sample_pt) begin
      bit_tick = 1'b1;
      next_r.bit_out = slice;
    end
    next_r.clk_out = r.phase[4];
    // sync detection
    sync_on = (r.cfg.demod_mode == `RXDD_MODE_SYNC2) ||
              (r.cfg.demod_mode == `RXDD_MODE_SYNC3);
    if (bit_tick) begin
      next_r.shreg = {r.shreg[22:0], slice};
      if (r.hold != 4'h0) next_r.hold = r.hold - 4'h1;
      if (r.hold == 4'h1) next_r.int_out = 1'b0;
    end
    if (bit_tick && sync_on && r.hold == 4'h0 &&
        errs <= {3'h0, r.cfg.sync_tol}) begin
      next_r.int_out = 1'b1;
      next_r.hold = 4'(`RXDD_HOLD_BITS);
    end
    // frequency estimate and pi loop
    is_fsk = r.cfg.demod_sel != `RXDD_DSEL_ASK;
    if (is_fsk) next_r.measured_if_frequency = 16'(r.favg);
    ferr = r.measured_if_frequency - $signed(`RXDD_IF_NOMINAL);
    lim  = r.cfg.if_bw_min ? $signed(`RXDD_FREQ_LIMIT_LO) : $signed(`RXDD_FREQ_LIMIT);
    prod = $signed({1'b0, r.cfg.freq_loop_scale}) * ferr;
    sum_adj = 24'sh0;
    if (r.cfg.freq_loop_enable_bit && is_fsk) begin
      next_r.integ = r.integ + 24'(prod >>> 16);
      sum_adj = next_r.integ + 24'(prod >>> 12);
      if (sum_adj > 24'(lim)) next_r.adj = lim;
      else if (sum_adj < -24'(lim)) next_r.adj = -lim;
      else next_r.adj = sum_adj[15:0];
    end else begin
      next_r.integ = 24'sh0;
      next_r.adj = 16'sh0;
    end
    // ahb-lite slave, zero wait states
    a_off = r.req.addr;
    if (r.ahb_st == RXDD_AHB_DATA && r.req.write) begin
      unique case (a_off)
        `RXDD_OFF_DEMOD: begin
          next_r.cfg.demod_sel = hwdata[`RXDD_DSEL_LSB +: 2];
          next_r.cfg.postfilter_bandwidth_value = hwdata[`RXDD_PBW_LSB +: 10];
          next_r.cfg.demod_mode = hwdata[`RXDD_MODE_LSB +: 3];
        end
        `RXDD_OFF_CORR: begin
          next_r.cfg.correlator_bandwidth_value = hwdata[`RXDD_CBW_LSB +: 10];
          next_r.cfg.correlator_odd_k_bit = hwdata[`RXDD_ODDK_BIT];
          next_r.cfg.rx_polarity_bit = hwdata[`RXDD_POL_BIT];
        end
        `RXDD_OFF_FREQ: begin
          next_r.cfg.freq_loop_scale = hwdata[`RXDD_SCALE_LSB +: 16];
          next_r.cfg.freq_loop_enable_bit = hwdata[`RXDD_FEN_BIT];
          next_r.cfg.if_bw_min = hwdata[`RXDD_FEN_BIT+1];
        end
        `RXDD_OFF_SYNC:    next_r.cfg.sync_word = hwdata[23:0];
        `RXDD_OFF_SYNCCFG: begin
          next_r.cfg.sync_len = hwdata[`RXDD_SLEN_LSB +: 2];
          next_r.cfg.sync_tol = hwdata[`RXDD_TOL_LSB +: 2];
        end
        default: ;
      endcase
    end
    next_r.ahb_st = RXDD_AHB_IDLE;
    next_r.req.sel = 1'b0;
    if (hsel && htrans[1] && hready) begin
      next_r.ahb_st = RXDD_AHB_DATA;
      next_r.req.sel = 1'b1;
      next_r.req.write = hwrite;
      next_r.req.addr = haddr[11:0];
      unique case (haddr[11:0])
        `RXDD_OFF_DEMOD:    next_r.rdata = {17'h0, next_r.cfg.demod_mode,
                                            next_r.cfg.postfilter_bandwidth_value,
                                            next_r.cfg.demod_sel};
        `RXDD_OFF_CORR:     next_r.rdata = {20'h0, next_r.cfg.rx_polarity_bit,
                                            next_r.cfg.correlator_odd_k_bit,
                                            next_r.cfg.correlator_bandwidth_value};
        `RXDD_OFF_FREQ:     next_r.rdata = {14'h0, next_r.cfg.if_bw_min,
                                            next_r.cfg.freq_loop_enable_bit,
                                            next_r.cfg.freq_loop_scale};
        `RXDD_OFF_SYNC:     next_r.rdata = {8'h0, next_r.cfg.sync_word};
        `RXDD_OFF_SYNCCFG:  next_r.rdata = {28'h0, next_r.cfg.sync_tol, next_r.cfg.sync_len};
        `RXDD_OFF_STATUS:   next_r.rdata = {27'h0, r.hold == 4'h0, r.int_out,
                                            r.bit_out, r.cfg.demod_sel};
        `RXDD_OFF_READBACK: next_r.rdata = {16'h0, r.measured_if_frequency};
        default:            next_r.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.ahb_st <= RXDD_AHB_IDLE;
      r.cfg.demod_sel <= `RXDD_DSEL_CORR;
    end else begin
      r <= next_r;
    end
  end

  assign hrdata         = r.rdata;
  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign rx_data        = r.bit_out;
  assign rx_clk         = r.clk_out;
  assign sync_match_int = r.int_out;
  assign freq_adjust    = r.adj;

  ////////////////////////////////////////////////////////////////////////////
  logic [3:0] a_ticks;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) a_ticks <= 4'h0;
    else if (!r.int_out) a_ticks <= 4'h0;
    else if (bit_tick) a_ticks <= a_ticks + 4'h1;
  end

  a_int_nine_bits: assert property (@(posedge clk_sys) disable iff (!rst_n)
    a_ticks <= 4'd9)
    else $error("match pin held past nine bits");
  a_sync_mode_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(r.int_out) |-> $past(sync_on))
    else $error("match outside sync mode");
  a_match_tol: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(r.int_out) |-> $past(errs) <= {3'h0, $past(r.cfg.sync_tol)})
    else $error("match beyond tolerance");
  a_adj_range: assert property (@(posedge clk_sys) disable iff (!rst_n)
    r.adj <= $signed(`RXDD_FREQ_LIMIT) && r.adj >= -$signed(`RXDD_FREQ_LIMIT))
    else $error("correction out of range");
  a_loop_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !r.cfg.freq_loop_enable_bit ##1 !r.cfg.freq_loop_enable_bit |-> r.adj == 16'sh0)
    else $error("correction while loop disabled");
  a_ask_no_afc: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (r.cfg.demod_sel == `RXDD_DSEL_ASK) [*2] |-> r.adj == 16'sh0)
    else $error("correction in ask mode");
  a_corr_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    r.cfg.demod_sel == `RXDD_DSEL_CORR |-> slice == ((r.filt > 0) ^ r.cfg.rx_polarity_bit))
    else $error("correlator threshold not zero");
  a_bit_spacing: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bit_tick |=> !bit_tick [*8])
    else $error("bit ticks too close");

  ////////////////////////////////////////////////////////////////////////////
  // cycles since the last bit tick, parked at all ones after reset
  logic [5:0] a_gap;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) a_gap <= 6'h3f;
    else if (bit_tick) a_gap <= 6'h00;
    else if (a_gap != 6'h3f) a_gap <= a_gap + 6'h01;
  end

  a_tick_gap: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bit_tick && a_gap != 6'h3f |-> a_gap >= 6'd23 && a_gap <= 6'd40)
    else $error("bit period outside tracking range");

  a_bus_okay: assert property (@(posedge clk_sys) disable iff (!rst_n)
    hresp == 1'b0 && hreadyout == 1'b1)
    else $error("bus response not okay");

  a_int_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bit_tick && r.hold == 4'h1 |=> !r.int_out)
    else $error("match pin not released");

  a_int_rise_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(r.int_out) |-> r.hold == 4'd9)
    else $error("hold count not loaded");

  a_int_stays: assert property (@(posedge clk_sys) disable iff (!rst_n)
    r.int_out && !(bit_tick && r.hold == 4'h1) |=> r.int_out)
    else $error("match pin dropped early");

  a_int_nine_fall: assert property (@(posedge clk_sys) disable iff (!rst_n)
    a_ticks == 4'd9 |-> !r.int_out)
    else $error("match pin high after ninth bit");

  a_match_on_tick: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(r.int_out) |-> $past(bit_tick))
    else $error("match away from bit tick");

  a_ask_rb_frozen: assert property (@(posedge clk_sys) disable iff (!rst_n)
    r.cfg.demod_sel == `RXDD_DSEL_ASK |=> r.measured_if_frequency == $past(r.measured_if_frequency))
    else $error("readback moved in ask mode");

  a_adj_range_lo: assert property (@(posedge clk_sys) disable iff (!rst_n)
    r.cfg.if_bw_min |=> r.adj <= $signed(`RXDD_FREQ_LIMIT_LO) &&
                        r.adj >= -$signed(`RXDD_FREQ_LIMIT_LO))
    else $error("correction beyond narrow range");

  a_integ_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !r.cfg.freq_loop_enable_bit |=> r.integ == 24'sh0)
    else $error("integrator kept while disabled");

  a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    r.ahb_st == RXDD_AHB_DATA && !r.req.write && r.req.addr == 12'h01c |-> hrdata == 32'h0)
    else $error("unmapped read not zero");

  a_sync_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    r.ahb_st == RXDD_AHB_DATA && r.req.write && r.req.addr == `RXDD_OFF_SYNC
    |=> r.cfg.sync_word == $past(hwdata[23:0]))
    else $error("sync word write lost");
endmodule : rxdd_top

// file: common/rxdd_cfg.svh
`ifndef RXDD_CFG_SVH
`define RXDD_CFG_SVH
// register byte offsets
`define RXDD_OFF_DEMOD     12'h000
`define RXDD_OFF_CORR      12'h004
`define RXDD_OFF_FREQ      12'h008
`define RXDD_OFF_SYNC      12'h00c
`define RXDD_OFF_SYNCCFG   12'h010
`define RXDD_OFF_STATUS    12'h014
`define RXDD_OFF_READBACK  12'h018
// demod register fields
`define RXDD_DSEL_LSB      0
`define RXDD_PBW_LSB       2
`define RXDD_MODE_LSB      12
// corr register fields
`define RXDD_CBW_LSB       0
`define RXDD_ODDK_BIT      10
`define RXDD_POL_BIT       11
// freq register fields
`define RXDD_SCALE_LSB     0
`define RXDD_FEN_BIT       16
// sync cfg fields
`define RXDD_SLEN_LSB      0
`define RXDD_TOL_LSB       2
// codes and counts
`define RXDD_DSEL_LIN      2'h0
`define RXDD_DSEL_CORR     2'h1
`define RXDD_DSEL_ASK      2'h2
`define RXDD_MODE_SYNC2    3'h2
`define RXDD_MODE_SYNC3    3'h3
`define RXDD_OVERSAMPLE    32
`define RXDD_HOLD_BITS     9
`define RXDD_IF_NOMINAL    16'h0520
`define RXDD_FREQ_LIMIT    16'h0280
`define RXDD_FREQ_LIMIT_LO 16'h0140
`endif

// file: common/rxdd_pkg.sv
package rxdd_pkg;
  typedef struct packed {
    logic [1:0]  demod_sel;
    logic [9:0]  postfilter_bandwidth_value;
    logic [2:0]  demod_mode;
    logic [9:0]  correlator_bandwidth_value;
    logic        correlator_odd_k_bit;
    logic        rx_polarity_bit;
    logic [15:0] freq_loop_scale;
    logic        freq_loop_enable_bit;
    logic        if_bw_min;
    logic [23:0] sync_word;
    logic [1:0]  sync_len;
    logic [1:0]  sync_tol;
  } rxdd_cfg_type;

  typedef enum logic [1:0] {
    RXDD_AHB_IDLE = 2'b01,
    RXDD_AHB_DATA = 2'b10
  } rxdd_ahb_state_type;

  typedef struct packed {
    logic       sel;
    logic       write;
    logic [11:0] addr;
  } rxdd_ahb_req_type;
endpackage : rxdd_pkg

// file: sim/rxdd_src_model.sv
module rxdd_src_model
  import rxdd_pkg::*;
#(
  parameter int DW = 16
) (
  input  wire logic                 tx_bit,
  input  wire logic signed [DW-1:0] if_bias,
  output logic signed [DW-1:0]      corr_upper,
  output logic signed [DW-1:0]      corr_lower,
  output logic signed [DW-1:0]      discrim_freq,
  output logic [6:0]                signal_strength
);
  timeunit 1ns;
  timeprecision 1ps;
  // levels never tie, so the bit decision is never a coin toss
  assign corr_upper      = tx_bit ? DW'(16'sh2000) : DW'(16'sh0400);
  assign corr_lower      = tx_bit ? DW'(16'sh0400) : DW'(16'sh2000);
  assign discrim_freq    = if_bias + (tx_bit ? DW'(16'sh0100) : -DW'(16'sh0100));
  assign signal_strength = tx_bit ? 7'h60 : 7'h08;
endmodule : rxdd_src_model

// file: sim/rxdd_tb_top.sv
`include "rxdd_cfg.svh"
module rxdd_tb_top
  import rxdd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BITC = `RXDD_OVERSAMPLE;
  typedef struct packed {
    logic [1:0] dsel;
    logic [2:0] mode;
    logic [1:0] len;
    logic [1:0] tol;
    logic [1:0] flips;
    logic       hit;
  } rxdd_row_type;
  logic               clk_sys, rst_n, hsel, hwrite, hready, hreadyout, hresp;
  logic               tx_bit, rx_data, rx_clk, sync_match_int, int_q, ck_q;
  int                 ck = 0, c0 = 0;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic [31:0]        haddr, hwdata, hrdata, rd;
  logic signed [15:0] corr_upper, corr_lower, discrim_freq, if_bias, freq_adjust;
  logic [6:0]         signal_strength;
  int                 mismatches = 0, comparisons = 0, rises = 0, hi_cyc = 0, hold_len = 0, r0;
  rxdd_row_type       rows [6] = '{
    '{2'h1, 3'h2, 2'h0, 2'h0, 2'h0, 1'b1},
    '{2'h0, 3'h3, 2'h1, 2'h0, 2'h0, 1'b1},
    '{2'h2, 3'h2, 2'h2, 2'h0, 2'h0, 1'b1},
    '{2'h1, 3'h3, 2'h3, 2'h3, 2'h3, 1'b1},
    '{2'h1, 3'h2, 2'h3, 2'h2, 2'h3, 1'b0},
    '{2'h1, 3'h0, 2'h0, 2'h0, 2'h0, 1'b0}};
  assign hready = hreadyout;
  rxdd_top #(.DW(16)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .corr_upper(corr_upper),
    .corr_lower(corr_lower), .discrim_freq(discrim_freq), .signal_strength(signal_strength),
    .rx_data(rx_data), .rx_clk(rx_clk), .sync_match_int(sync_match_int),
    .freq_adjust(freq_adjust));
  rxdd_src_model #(.DW(16)) src_u (.tx_bit(tx_bit), .if_bias(if_bias),
    .corr_upper(corr_upper), .corr_lower(corr_lower), .discrim_freq(discrim_freq),
    .signal_strength(signal_strength));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // width of the last complete pulse on the match pin
  always @(posedge clk_sys) begin
    int_q <= sync_match_int;
    ck_q <= rx_clk;
    if (rx_clk === 1'b1 && ck_q !== 1'b1) ck <= ck + 1;
    if (sync_match_int === 1'b1 && int_q !== 1'b1) rises <= rises + 1;
    if (sync_match_int === 1'b1) hi_cyc <= hi_cyc + 1;
    else if (int_q === 1'b1) begin
      hold_len <= hi_cyc;
      hi_cyc <= 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wt;
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
  endtask : wt
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    wt();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wt();
    r = hrdata;
  endtask : ahb
  task automatic send(input logic [23:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      tx_bit <= w[i];
      repeat (BITC) @(posedge clk_sys);
    end
  endtask : send
  function automatic logic inlim(input logic signed [15:0] v, input logic signed [15:0] l);
    return v !== 16'sh0 && v <= l && v >= -l;
  endfunction : inlim
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #2_000_000;
    mismatches++;
    end_of_test();
  end
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    tx_bit = 1'b0;
    if_bias = 16'sh0520;
    repeat (10) @(posedge clk_sys);
    chk({29'h0, hreadyout, hresp, sync_match_int}, 32'h4);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    ahb(1'b0, `RXDD_OFF_DEMOD, 32'h0, rd);
    chk(rd, 32'h1);
    ahb(1'b0, 12'h01c, 32'h0, rd);
    chk(rd, 32'h0);
    // k = 8: even k, even k/2, so both correlator bits stay clear
    ahb(1'b1, `RXDD_OFF_CORR, 32'h1f4, rd);
    ahb(1'b0, `RXDD_OFF_CORR, 32'h0, rd);
    chk(rd, 32'h1f4);
    ahb(1'b1, `RXDD_OFF_SYNC, 32'hd3a5c6, rd);
    $display("test registers done");
    foreach (rows[i]) begin
      ahb(1'b1, `RXDD_OFF_DEMOD, 32'({rows[i].mode, 10'd151, rows[i].dsel}), rd);
      ahb(1'b1, `RXDD_OFF_SYNCCFG, 32'({rows[i].tol, rows[i].len}), rd);
      r0 = rises;
      c0 = ck;
      send(24'haaaaaa, 24);
      send(24'hd3a5c6 ^ ~(24'hffffff << rows[i].flips), 12 + 4 * int'(rows[i].len));
      send(24'haaaaaa, 12);
      chk(32'(rises - r0), 32'(rows[i].hit));
      chk({31'h0, rx_data}, 32'h0);
      chk(32'(ck - c0 >= 40), 32'h1);
      if (rows[i].hit)
        chk(32'(hold_len >= 9 * BITC - 2 && hold_len <= 9 * BITC + 2), 32'h1);
      $display("test sync row %0d done", i);
    end
    // large offset so the loop has real error to chase
    if_bias <= 16'sh2520;
    ahb(1'b1, `RXDD_OFF_DEMOD, 32'({3'h2, 10'd151, `RXDD_DSEL_ASK}), rd);
    ahb(1'b1, `RXDD_OFF_FREQ, 32'h100a8, rd);
    repeat (2000) @(posedge clk_sys);
    chk(32'(freq_adjust), 32'h0);
    ahb(1'b1, `RXDD_OFF_DEMOD, 32'({3'h2, 10'd151, `RXDD_DSEL_CORR}), rd);
    repeat (4000) @(posedge clk_sys);
    chk(32'(inlim(freq_adjust, $signed(`RXDD_FREQ_LIMIT))), 32'h1);
    ahb(1'b1, `RXDD_OFF_FREQ, 32'h300a8, rd);
    repeat (4000) @(posedge clk_sys);
    chk(32'(inlim(freq_adjust, $signed(`RXDD_FREQ_LIMIT_LO))), 32'h1);
    $display("test freq loop done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk({16'h0, freq_adjust}, 32'h0);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    ahb(1'b0, `RXDD_OFF_DEMOD, 32'h0, rd);
    chk(rd, 32'h1);
    $display("test second reset done");
    end_of_test();
  end
endmodule : rxdd_tb_top
